// ===== rtl/mgm_map.vh
`ifndef MGM_MAP_VH
`define MGM_MAP_VH
// Register word addresses (byte address = word index * 4)
`define MGM_ADR_OVR_EN      4'h0
`define MGM_ADR_OVR_VAL     4'h1
`define MGM_ADR_MASK_CTRL   4'h2
`define MGM_ADR_GATE_MON    4'h3
`define MGM_ADR_STATUS      4'h4
// Mask control field positions
`define MGM_MC_ARM_SIDE     0
`define MGM_MC_PROT_DRIVE   1
`define MGM_MC_PWM_GATE     2
`define MGM_MC_PAIR_STYLE   3
`define MGM_MC_MASK_SRC     7
// Reset values
`define MGM_RST_MASK_CTRL   8'h04
`define MGM_RST_OVR         6'h00
// Writable bits of mask control
`define MGM_MC_WMASK        8'h8f
`endif

// ===== rtl/mgm_phase_mask.v
`default_nettype none
// One transistor pair: commutation command plus PWM to top/bottom commands
module mgm_phase_mask (
  // Commands and PWM
  input  wire       top_cmd_i,
  input  wire       bot_cmd_i,
  input  wire       pwm_i,
  input  wire       pwm_inv_i,
  // Settings
  input  wire       arm_side_i,
  input  wire       pair_style_i,
  input  wire       pwm_gate_i,
  // Result
  output reg        top_o,
  output reg        bot_o
);
  reg pwm_t;
  reg pwm_b;

  // PWM gate off means the PWM side behaves as steady on
  always @* begin
    pwm_t = pwm_gate_i ? pwm_i : 1'b1;
    pwm_b = pwm_gate_i ? pwm_inv_i : 1'b0;
    top_o = 1'b0;
    bot_o = 1'b0;
    case ({top_cmd_i, bot_cmd_i})
      2'b01: begin
        if (!arm_side_i) begin
          bot_o = pwm_t;
          top_o = pair_style_i ? 1'b0 : pwm_b;
        end else begin
          bot_o = 1'b1;
        end
      end
      2'b10: begin
        if (arm_side_i) begin
          top_o = pwm_t;
          bot_o = pair_style_i ? 1'b0 : pwm_b;
        end else begin
          top_o = 1'b1;
        end
      end
      default: begin
        top_o = 1'b0;
        bot_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== rtl/mgm_gate_mask.v
`include "mgm_map.vh"
`default_nettype none
// Function
// - Mask stage runs in normal, brake or motor protect mode.
// - Mask source bit selects table masking (0) or override registers (1).
// - PWM gate bit 0 removes PWM from all phase commands.
// - Arm side bit puts PWM on bottom arms (0) or top arms (1).
// - Pair style bit selects complementary (0) or non-complementary (1).
// - Complementary: PWM arm gets PWM, partner inverted; 00/11 both low.
// - Non-complementary: PWM arm gets PWM, partner 0; 00/11 both low.
// - Arm side and pair style act in both mask sources.
// - Override enable replaces each channel's generator signal by its value.
// - Override value drives the channel low or high while enabled.
// - Pair both overridden high drives both channels of the pair low.
// - With complementary PWM, non-PWM channel stays at or below the table value unless its PWM arm is overridden.
// - Channels used as general I/O ignore the override value, except in the pair both-overridden-high rule.
// - Brake has top priority: tops 0, bottoms 1.
// - Protect: drive select 0 all off, 1 tops 0 bottoms 1.
// - Monitor bits 5..3 show gate A high, A low, B high.
// - Monitor bits 2..0 show filtered Hall C, B, A.
// - Brake request comes from the Hall decoder control brake bit.
module mgm_gate_mask (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  // Commutation commands, top/bottom per phase A,B,C
  input  wire        phase_a_top_cmd_i,
  input  wire        phase_a_bottom_cmd_i,
  input  wire        phase_b_top_cmd_i,
  input  wire        phase_b_bottom_cmd_i,
  input  wire        phase_c_top_cmd_i,
  input  wire        phase_c_bottom_cmd_i,
  // PWM from generator, one per phase
  input  wire [2:0]  pwm_true_i,
  input  wire [2:0]  pwm_inverted_i,
  // Hall decoder and protection inputs
  input  wire        brake_request_i,
  input  wire        protect_fault_i,
  input  wire [2:0]  hall_filtered_i,
  input  wire [5:0]  channel_gpio_i,
  // Gate drive commands
  output reg         gate_a_high_o,
  output reg         gate_a_low_o,
  output reg         gate_b_high_o,
  output reg         gate_b_low_o,
  output reg         gate_c_high_o,
  output reg         gate_c_low_o,
  // Mode status
  output reg  [1:0]  mode_o
);
  // Operating modes; the same codes are reported on mode_o
  // so a supervisor can see why the gates are being held
  localparam [1:0] MODE_NORMAL  = 2'b00;
  localparam [1:0] MODE_BRAKE   = 2'b01;
  localparam [1:0] MODE_PROTECT = 2'b10;

  // Registers; override and monitor have flops for their six bits only,
  // mask control keeps all eight, and the read mux pads or masks the
  // rest to zero, so software always sees clean upper bits
  reg  [5:0] channel_override_enable_reg;
  reg  [5:0] channel_override_value_reg;
  reg  [7:0] mask_control_reg;
  reg  [5:0] gate_monitor_reg;

  // Synchronisers for pin level inputs
  reg  [1:0] brake_sync;
  reg  [1:0] fault_sync;
  reg  [2:0] hall_meta;
  reg  [2:0] hall_sync;
  reg  [5:0] gpio_meta;
  reg  [5:0] gpio_sync;

  wire       arm_side_select;
  wire       protect_drive_select;
  wire       pwm_output_gate;
  wire       pair_drive_style;
  wire       mask_source_select;
  assign arm_side_select      = mask_control_reg[`MGM_MC_ARM_SIDE];
  assign protect_drive_select = mask_control_reg[`MGM_MC_PROT_DRIVE];
  assign pwm_output_gate      = mask_control_reg[`MGM_MC_PWM_GATE];
  assign pair_drive_style     = mask_control_reg[`MGM_MC_PAIR_STYLE];
  assign mask_source_select   = mask_control_reg[`MGM_MC_MASK_SRC];

  // Merge a byte write into a register under its byte enable.
  // Bits outside the write mask keep their stored value, so fields
  // without storage can never pick up written data.
  function [7:0] mgm_wr_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input [7:0] wmask;
    input       lane_en;
    begin
      if (lane_en)
        mgm_wr_byte = (old_val & ~wmask) | (new_val & wmask);
      else
        mgm_wr_byte = old_val;
    end
  endfunction

  // Two-flop synchronisers; first stage feeds only the second.
  // Brake, fault, Hall and I/O select come from other domains, so
  // they reach the mask two edges late; commands and PWM do not.
  // A request shorter than one clock may therefore be missed.
  always @(posedge clk_i) begin
    if (rst_i) begin
      brake_sync <= 2'b00;
      fault_sync <= 2'b00;
      hall_meta  <= 3'h0;
      hall_sync  <= 3'h0;
      gpio_meta  <= 6'h00;
      gpio_sync  <= 6'h00;
    end else begin
      brake_sync <= {brake_sync[0], brake_request_i};
      fault_sync <= {fault_sync[0], protect_fault_i};
      hall_meta  <= hall_filtered_i;
      hall_sync  <= hall_meta;
      gpio_meta  <= channel_gpio_i;
      gpio_sync  <= gpio_meta;
    end
  end

  // Table path: each pair mapped from its commutation command.
  // Commands and PWM come from logic on this clock and are used
  // unsynchronised, which keeps their path to the pins one cycle.
  wire [2:0] tbl_top;
  wire [2:0] tbl_bot;
  wire [2:0] top_cmd;
  wire [2:0] bot_cmd;
  assign top_cmd = {phase_c_top_cmd_i, phase_b_top_cmd_i,
                    phase_a_top_cmd_i};
  assign bot_cmd = {phase_c_bottom_cmd_i, phase_b_bottom_cmd_i,
                    phase_a_bottom_cmd_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
      mgm_phase_mask u_pm (
        .top_cmd_i    (top_cmd[gi]),
        .bot_cmd_i    (bot_cmd[gi]),
        .pwm_i        (pwm_true_i[gi]),
        .pwm_inv_i    (pwm_inverted_i[gi]),
        .arm_side_i   (arm_side_select),
        .pair_style_i (pair_drive_style),
        .pwm_gate_i   (pwm_output_gate),
        .top_o        (tbl_top[gi]),
        .bot_o        (tbl_bot[gi])
      );
    end
  endgenerate

  // Software path: channel 2n is top, 2n+1 bottom of pair n.
  // Generator signal is the table result so arm side and style still act.
  // A channel whose pin is general I/O keeps the generator signal unless both arms of its pair are overridden high.
  // Limitation: one arm overridden high against a partner that the
  // table drives high is not blocked; software must avoid it.
  reg  [5:0] gen_sig;
  reg  [5:0] sw_sig;
  reg  [5:0] norm_sig;
  integer    k;
  always @* begin
    gen_sig  = 6'h00;
    sw_sig   = 6'h00;
    norm_sig = 6'h00;
    for (k = 0; k < 3; k = k + 1) begin
      gen_sig[2*k]   = tbl_top[k];
      gen_sig[2*k+1] = tbl_bot[k];
    end
    for (k = 0; k < 6; k = k + 1) begin
      if (channel_override_enable_reg[k] && !gpio_sync[k])
        sw_sig[k] = channel_override_value_reg[k];
      else
        sw_sig[k] = gen_sig[k];
    end
    for (k = 0; k < 3; k = k + 1) begin
      // Both overridden high would short the pair
      if (channel_override_enable_reg[2*k] &&
          channel_override_enable_reg[2*k+1] &&
          channel_override_value_reg[2*k] &&
          channel_override_value_reg[2*k+1]) begin
        sw_sig[2*k]   = 1'b0;
        sw_sig[2*k+1] = 1'b0;
      end
      // Complementary PWM: partner of a non-overridden PWM arm never exceeds the table
      if (pwm_output_gate && !pair_drive_style) begin
        if (arm_side_select && !channel_override_enable_reg[2*k])
          sw_sig[2*k+1] = sw_sig[2*k+1] & gen_sig[2*k+1];
        if (!arm_side_select && !channel_override_enable_reg[2*k+1])
          sw_sig[2*k] = sw_sig[2*k] & gen_sig[2*k];
      end
    end
    norm_sig = mask_source_select ? sw_sig : gen_sig;
  end

  // Gate patterns, bit 2n top and 2n+1 bottom of phase n.
  // Brake turns every bottom arm on and every top arm off.
  localparam [5:0] GATES_OFF   = 6'h00;
  localparam [5:0] GATES_BRAKE = 6'h2a;

  // Mode priority: brake, then motor protect, then normal.
  // Both requests are pins, so they act only after the synchroniser
  // and hold the gates for as long as they stand.
  reg [1:0] next_mode;
  always @* begin
    if (brake_sync[1])
      next_mode = MODE_BRAKE;
    else if (fault_sync[1])
      next_mode = MODE_PROTECT;
    else
      next_mode = MODE_NORMAL;
  end

  // Gate command for the chosen mode. Brake and protect ignore the
  // commutation commands and the overrides entirely, so software
  // cannot turn a top arm on while either of them stands.
  reg [5:0] next_gate;
  always @* begin
    case (next_mode)
      MODE_BRAKE:   next_gate = GATES_BRAKE;
      MODE_PROTECT: next_gate = protect_drive_select ?
                                GATES_BRAKE : GATES_OFF;
      MODE_NORMAL:  next_gate = norm_sig;
      default:      next_gate = GATES_OFF;
    endcase
  end

  // Gate pins and mode come from flops, so the external driver never
  // sees a glitch from the combinational mask path; the cost is one
  // cycle of latency on every change.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_o        <= MODE_NORMAL;
      gate_a_high_o <= 1'b0;
      gate_a_low_o  <= 1'b0;
      gate_b_high_o <= 1'b0;
      gate_b_low_o  <= 1'b0;
      gate_c_high_o <= 1'b0;
      gate_c_low_o  <= 1'b0;
      gate_monitor_reg <= 6'h00;
    end else begin
      mode_o        <= next_mode;
      gate_a_high_o <= next_gate[0];
      gate_a_low_o  <= next_gate[1];
      gate_b_high_o <= next_gate[2];
      gate_b_low_o  <= next_gate[3];
      gate_c_high_o <= next_gate[4];
      gate_c_low_o  <= next_gate[5];
      // Monitor loads A high, A low and B high as the gate pins do, plus synchronised Hall
      gate_monitor_reg <= {next_gate[0], next_gate[1], next_gate[2],
                           hall_sync[2], hall_sync[1], hall_sync[0]};
    end
  end

  // Wishbone slave: one wait cycle, ack or err for one cycle.
  // The answer is registered, and a held request is not taken again
  // while its answer stands, so each bus cycle is served once.
  wire       req;
  wire       mapped;
  wire       wr_take;
  wire       rd_take;
  assign req     = cyc_i && stb_i && !ack_o && !err_o;
  assign mapped  = (adr_i <= `MGM_ADR_GATE_MON);
  assign wr_take = req && mapped && we_i;
  assign rd_take = req && mapped && !we_i;

  // Per-register write strobes. The monitor has no strobe, so a
  // write to it is answered with ack but changes nothing.
  wire       wr_ovr_en;
  wire       wr_ovr_val;
  wire       wr_mask_ctrl;
  assign wr_ovr_en    = wr_take && (adr_i == `MGM_ADR_OVR_EN);
  assign wr_ovr_val   = wr_take && (adr_i == `MGM_ADR_OVR_VAL);
  assign wr_mask_ctrl = wr_take && (adr_i == `MGM_ADR_MASK_CTRL);

  // Byte lane 0 merged under its enable and the writable mask.
  // The merge is a byte wide; the override registers keep only the
  // six implemented bits, so the top two are cut on purpose.
  wire [7:0] ovr_en_merge;
  wire [7:0] ovr_val_merge;
  wire [7:0] mask_ctrl_merge;
  assign ovr_en_merge    = mgm_wr_byte({2'b00, channel_override_enable_reg},
                                       dat_i[7:0], 8'h3f, sel_i[0]);
  assign ovr_val_merge   = mgm_wr_byte({2'b00, channel_override_value_reg},
                                       dat_i[7:0], 8'h3f, sel_i[0]);
  assign mask_ctrl_merge = mgm_wr_byte(mask_control_reg, dat_i[7:0],
                                       `MGM_MC_WMASK, sel_i[0]);

  // Read mux; the monitor is read here but never written
  reg  [7:0] rd_byte;
  always @* begin
    case (adr_i)
      `MGM_ADR_OVR_EN:    rd_byte = {2'b00, channel_override_enable_reg};
      `MGM_ADR_OVR_VAL:   rd_byte = {2'b00, channel_override_value_reg};
      `MGM_ADR_MASK_CTRL: rd_byte = mask_control_reg & `MGM_MC_WMASK;
      `MGM_ADR_GATE_MON:  rd_byte = {2'b00, gate_monitor_reg};
      default:            rd_byte = 8'h00;
    endcase
  end

  // Register storage; a write lands at the edge that takes it
  always @(posedge clk_i) begin
    if (rst_i) begin
      channel_override_enable_reg <= `MGM_RST_OVR;
      channel_override_value_reg  <= `MGM_RST_OVR;
      mask_control_reg            <= `MGM_RST_MASK_CTRL;
    end else begin
      if (wr_ovr_en) begin
        channel_override_enable_reg <= ovr_en_merge[5:0];
      end
      if (wr_ovr_val) begin
        channel_override_value_reg <= ovr_val_merge[5:0];
      end
      if (wr_mask_ctrl) begin
        mask_control_reg <= mask_ctrl_merge;
      end
    end
  end

  // Bus answer; read data stands with ack only and is zero at all
  // other times, so a stale value is never mistaken for an answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      dat_o <= rd_take ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

// ===== tb/mgm_gate_mask_asserts.sv
`default_nettype none
// Bus answer and mode priority checks on the top pins
module mgm_gate_mask_asserts (
  // Clock and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [3:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  // Mode inputs and gates
  input wire logic        brake_request_i,
  input wire logic        protect_fault_i,
  input wire logic        gate_a_high_o,
  input wire logic        gate_a_low_o,
  input wire logic        gate_b_high_o,
  input wire logic        gate_b_low_o,
  input wire logic        gate_c_high_o,
  input wire logic        gate_c_low_o,
  input wire logic [1:0]  mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and gates packed A..C
  wire logic       take = cyc_i && stb_i && !ack_o && !err_o;
  wire logic [5:0] g = {gate_a_high_o, gate_a_low_o, gate_b_high_o,
                        gate_b_low_o, gate_c_high_o, gate_c_low_o};
  wire logic       prot = protect_fault_i && !brake_request_i;
  // Pin paths take two sync stages plus the output flop
  AST_BRAKE_GATES: assert property (brake_request_i [*3] |=>
    g == 6'b010101) else $error("brake pattern wrong");
  AST_BRAKE_MODE: assert property (brake_request_i [*3] |=>
    mode_o == 2'd1) else $error("brake mode wrong");
  AST_PROT_TOPS: assert property (prot [*3] |=>
    !g[5] && !g[3] && !g[1]) else $error("protect top on");
  AST_PROT_MODE: assert property (prot [*3] |=>
    mode_o == 2'd2) else $error("protect mode wrong");
  AST_ACK_NEXT: assert property (take && adr_i < 4'h4 |=>
    ack_o && !err_o) else $error("no ack");
  AST_ERR_ADR: assert property (take && adr_i > 4'h3 |=>
    err_o && !ack_o && dat_o == 32'h0) else $error("no err");
  AST_ONE_PULSE: assert property ((ack_o || err_o) |=>
    !ack_o && !err_o) else $error("answer too long");
  AST_UPPER_ZERO: assert property (ack_o |->
    dat_o[31:8] == 24'h0) else $error("upper bits set");
endmodule
bind mgm_gate_mask mgm_gate_mask_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .brake_request_i(brake_request_i), .protect_fault_i(protect_fault_i),
  .gate_a_high_o(gate_a_high_o), .gate_a_low_o(gate_a_low_o),
  .gate_b_high_o(gate_b_high_o), .gate_b_low_o(gate_b_low_o),
  .gate_c_high_o(gate_c_high_o), .gate_c_low_o(gate_c_low_o),
  .mode_o(mode_o));
`default_nettype wire

// ===== tb/mgm_drv_model.sv
`default_nettype none
// Transistor pairs: flag any pair with both arms on
module mgm_drv_model (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic [5:0] gate_i,
  output var logic       shoot_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Sticky, so one bad cycle between probes is not lost
  always @(posedge clk_i) begin
    if (rst_i) begin
      shoot_o <= 1'b0;
    end else if (|(gate_i[5:0] & {gate_i[4:0], 1'b0} & 6'h2a)) begin
      shoot_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/motor_gate_mask_logic_bench.sv
`include "mgm_map.vh"
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, a); num_errors++; end end
module motor_gate_mask_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [3:0]  adr_i = 0;
  logic [31:0] dat_i = 0, seed = 32'hb393;
  logic [5:0]  cmd = 0, gpio = 0;
  logic [2:0]  pt = 0, hall = 0, p;
  logic        brk = 0, flt = 0, probe = 0;
  logic [8:0]  q[$];
  logic [7:0]  mc;
  wire  [31:0] dat_o;
  wire  [5:0]  g;
  wire  [1:0]  mode;
  wire         ack_o, err_o, shoot;
  int          num_errors = 0, n_checks = 0, k;
  mgm_gate_mask dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .phase_a_top_cmd_i(cmd[5]), .phase_a_bottom_cmd_i(cmd[4]),
    .phase_b_top_cmd_i(cmd[3]), .phase_b_bottom_cmd_i(cmd[2]),
    .phase_c_top_cmd_i(cmd[1]), .phase_c_bottom_cmd_i(cmd[0]),
    .pwm_true_i(pt), .pwm_inverted_i(~pt), .brake_request_i(brk),
    .protect_fault_i(flt), .hall_filtered_i(hall),
    .channel_gpio_i(gpio), .gate_a_high_o(g[5]), .gate_a_low_o(g[4]),
    .gate_b_high_o(g[3]), .gate_b_low_o(g[2]), .gate_c_high_o(g[1]),
    .gate_c_low_o(g[0]), .mode_o(mode));
  mgm_drv_model u_drv (.clk_i(clk_i), .rst_i(rst_i), .gate_i(g),
    .shoot_o(shoot));
  always #25 clk_i = ~clk_i;
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Oldest note against the read data or the probed gates
  always @(posedge clk_i) begin
    if (((ack_o || err_o) && !we_i) || probe) begin
      `CHK("result", (q.size() ? q.pop_front() : 9'h1ff),
           (probe ? {1'b1, mode, g} : {1'b0, dat_o[7:0]}))
    end
  end
  // Classic cycle, held until the answer; a hang ends the run
  task automatic wb(input logic [3:0] a, input logic w,
                    input logic [7:0] d);
    int i;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i} <= {2'b11, w, a};
    dat_i <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (!(ack_o || err_o) && i < 20);
    {cyc_i, stb_i} <= 2'b00;
    if (!(ack_o || err_o)) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    q.push_back({1'b0, e});
    wb(a, 1'b0, 8'h00);
  endtask
  // Three cycles covers the slowest pin path
  task automatic gchk(input logic [5:0] e, input logic [1:0] m);
    repeat (3) @(posedge clk_i);
    q.push_back({1'b1, m, e});
    probe <= 1'b1;
    @(posedge clk_i);
    probe <= 1'b0;
  endtask
  // Pair output for command c, PWM p, side, style, PWM gate
  function automatic logic [1:0] arm(logic [1:0] c, logic p, logic sd,
                                     logic st, logic ge);
    logic v;
    v = ge ? p : 1'b1;
    if (c == 2'b01) arm = sd ? 2'b01 : {~st & ~v, v};
    else if (c == 2'b10) arm = sd ? {v, ~st & ~v} : 2'b10;
    else arm = 2'b00;
  endfunction
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`MGM_ADR_MASK_CTRL, 8'h04);
    rd(`MGM_ADR_OVR_EN, 8'h00);
    rd(4'h9, 8'h00);
    wb(`MGM_ADR_MASK_CTRL, 1'b1, 8'hff);
    rd(`MGM_ADR_MASK_CTRL, 8'h8f);
    for (k = 0; k < 32; k++) begin
      mc = {4'h0, k[2], k[3], 1'b0, k[4]};
      wb(`MGM_ADR_MASK_CTRL, 1'b1, mc);
      p = 3'($random(seed));
      pt <= p;
      cmd <= {3{k[1:0]}};
      gchk({arm(k[1:0], p[0], k[4], k[2], k[3]), arm(k[1:0], p[1], k[4],
        k[2], k[3]), arm(k[1:0], p[2], k[4], k[2], k[3])}, 2'd0);
    end
    wb(`MGM_ADR_MASK_CTRL, 1'b1, 8'h84);
    cmd <= 6'b010001;
    pt <= 3'b101;
    wb(`MGM_ADR_OVR_VAL, 1'b1, 8'h17);
    wb(`MGM_ADR_OVR_EN, 1'b1, 8'h1f);
    gchk(6'b001001, 2'd0);
    gpio <= 6'b000100;
    gchk(6'b000001, 2'd0);
    wb(`MGM_ADR_OVR_VAL, 1'b1, 8'hff);
    rd(`MGM_ADR_OVR_VAL, 8'h3f);
    {brk, flt} <= 2'b11;
    gchk(6'b010101, 2'd1);
    brk <= 1'b0;
    wb(`MGM_ADR_MASK_CTRL, 1'b1, 8'h04);
    gchk(6'b000000, 2'd2);
    wb(`MGM_ADR_MASK_CTRL, 1'b1, 8'h06);
    gchk(6'b010101, 2'd2);
    wb(`MGM_ADR_MASK_CTRL, 1'b1, 8'h04);
    {flt, gpio, pt, cmd} <= {7'h0, 3'b000, 6'b100100};
    hall <= 3'($random(seed));
    gchk(6'b101000, 2'd0);
    rd(`MGM_ADR_GATE_MON, {2'b00, 3'b101, hall});
    `CHK("shoot", 1'b0, shoot)
    report_and_stop();
  end
endmodule
`default_nettype wire
